// >>> design/rsc_pkg.sv
// constants and types of the reset source collector
// What this block does
// [R01] supply reset asserts low, releases above high
// [R02] core or memory monitor drives combined source
// [R03] external pin glitch filtered, about 12 us
// [R04] low pulses under 1 us ignored
// [R05] watchdog expiry raises watchdog source
// [R06] cpu software request is distinct source
// [R07] failed config check raises config source
// [R08] retry check, park after third failure
// [R09] parked state forces readout protection
// [R10] debug reset bit gives debug source
// [R11] test port reset touches only tap
// [R12] test reset ignored in two-wire or disabled
// [R13] five outputs derived from collected sources
// [R14] record cause of last restart
// [R15] sources assert async, release synchronously
package rsc_pkg;
  localparam int CLK_MHZ = 100;
  // filter time in ns, nominal figure
  localparam int FILT_NS = 12000;
  localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_W = 11;
  localparam logic [FILT_W-1:0] FILT_MAX = FILT_W'(FILT_CYC - 1);
  localparam logic [1:0] MAX_FAIL = 2'h3;
  localparam int CAUSE_W = 3;
  typedef enum logic [CAUSE_W-1:0] {
    RSC_CAUSE_NONE = 3'h0,
    RSC_CAUSE_AON = 3'h1,
    RSC_CAUSE_LV = 3'h2,
    RSC_CAUSE_PIN = 3'h3,
    RSC_CAUSE_WDOG = 3'h4,
    RSC_CAUSE_SW = 3'h5,
    RSC_CAUSE_CFG = 3'h6,
    RSC_CAUSE_WAKE = 3'h7
  } rsc_cause_t;
  typedef enum logic [1:0] {
    RSC_CHECK = 2'b00,
    RSC_RUN = 2'b01,
    RSC_RETRY = 2'b10,
    RSC_PARK = 2'b11
  } rsc_state_t;
endpackage

// >>> design/rsc_rst_sync.sv
// reset source synchroniser: async assert, synchronous release
`timescale 1ns/1ns
`default_nettype none
module rsc_rst_sync (
  input wire logic clock,
  rsc_sync_if.sync port
);
  logic stage1;
  logic stage2;
  assign port.srcSync = stage2;
  // [R15]
  always_ff @(posedge clock or posedge port.srcAsync) begin
    if (port.srcAsync) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
    end else begin
      stage1 <= 1'b0;
      stage2 <= stage1;
    end
  end
endmodule
`default_nettype wire

// >>> design/rsc_sync_if.sv
// interface between top and reset synchroniser
`timescale 1ns/1ns
`default_nettype none
interface rsc_sync_if;
  logic srcAsync;
  logic srcSync;
  modport top(output srcAsync, input srcSync);
  modport sync(input srcAsync, output srcSync);
endinterface
`default_nettype wire

// >>> design/rsc_top.sv
// reset source collector top
`timescale 1ns/1ns
`default_nettype none
module rsc_top
  import rsc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic alwaysOnSupplyMonitor,
  input wire logic coreSupplyMonitor,
  input wire logic memorySupplyMonitor,
  input wire logic externalResetPin_n,
  input wire logic watchdogExpire,
  input wire logic softwareResetRequest,
  input wire logic configCheckDone,
  input wire logic configCheckFail,
  input wire logic debugPortResetRequest,
  input wire logic deepSleepWake,
  input wire logic testPortResetPin_n,
  input wire logic twoWireMode,
  input wire logic debugPortDisable,
  output logic configCheckStart,
  output logic emulatedDeepSleep,
  output logic forceReadoutProtect,
  output logic fullCpuDebugReset,
  output logic cpuOnlyReset,
  output logic debugAccessReset,
  output logic retainedPeriphReset,
  output logic corePeriphReset,
  output logic tapReset,
  output logic [CAUSE_W-1:0] resetCause
);
  // ****************************************************
  // supply sources
  // ****************************************************
  // monitors carry their own threshold hysteresis; high means below threshold
  logic combinedLowVoltageMonitor;
  assign combinedLowVoltageMonitor = coreSupplyMonitor | memorySupplyMonitor; // [R02]
  rsc_sync_if aonIf();
  rsc_sync_if lvIf();
  assign aonIf.srcAsync = alwaysOnSupplyMonitor | ~rst_n; // [R01]
  assign lvIf.srcAsync = combinedLowVoltageMonitor; // [R01]
  rsc_rst_sync aonSync (.clock(clock), .port(aonIf.sync));
  rsc_rst_sync lvSync (.clock(clock), .port(lvIf.sync));
  logic aonRst;
  logic lvRst;
  assign aonRst = aonIf.srcSync;
  assign lvRst = lvIf.srcSync;

  // ****************************************************
  // external pin filter
  // ****************************************************
  logic pinMeta;
  logic pinSync;
  logic next_pinMeta;
  logic next_pinSync;
  logic pinFilt;
  logic next_pinFilt;
  logic [FILT_W-1:0] filtCnt;
  logic [FILT_W-1:0] next_filtCnt;
  // pin idles high, so the stages reset high and no false low follows reset
  always_comb begin
    next_pinMeta = externalResetPin_n;
    next_pinSync = pinMeta;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta <= 1'b1;
      pinSync <= 1'b1;
    end else begin
      pinMeta <= next_pinMeta;
      pinSync <= next_pinSync;
    end
  end
  // the level must persist the full filter time before it switches
  always_comb begin
    next_pinFilt = pinFilt;
    next_filtCnt = '0;
    if (pinSync != pinFilt) begin
      if (filtCnt == FILT_MAX) begin
        next_pinFilt = pinSync; // [R03]
      end else begin
        next_filtCnt = filtCnt + 1'b1; // [R04]
      end
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pinFilt <= 1'b1;
      filtCnt <= '0;
    end else begin
      pinFilt <= next_pinFilt;
      filtCnt <= next_filtCnt;
    end
  end

  // ****************************************************
  // logic sources
  // ****************************************************
  // same-domain request pulses stretched through synchronisers
  rsc_sync_if pinIf();
  rsc_sync_if wdIf();
  rsc_sync_if swIf();
  rsc_sync_if dbgIf();
  rsc_sync_if cfgIf();
  logic cfgErr;
  assign pinIf.srcAsync = ~pinFilt; // [R03]
  assign wdIf.srcAsync = watchdogExpire; // [R05]
  assign swIf.srcAsync = softwareResetRequest; // [R06]
  assign dbgIf.srcAsync = debugPortResetRequest; // [R10]
  assign cfgIf.srcAsync = cfgErr; // [R07]
  rsc_rst_sync pinSyncU (.clock(clock), .port(pinIf.sync));
  rsc_rst_sync wdSync (.clock(clock), .port(wdIf.sync));
  rsc_rst_sync swSync (.clock(clock), .port(swIf.sync));
  rsc_rst_sync dbgSync (.clock(clock), .port(dbgIf.sync));
  rsc_rst_sync cfgSync (.clock(clock), .port(cfgIf.sync));
  logic pinRst;
  logic wdRst;
  logic swRst;
  logic dbgRst;
  logic cfgRst;
  assign pinRst = pinIf.srcSync;
  assign wdRst = wdIf.srcSync;
  assign swRst = swIf.srcSync;
  assign dbgRst = dbgIf.srcSync;
  assign cfgRst = cfgIf.srcSync;

  // ****************************************************
  // config check sequencer
  // ****************************************************
  rsc_state_t state;
  rsc_state_t next_state;
  logic [1:0] failCnt;
  logic [1:0] next_failCnt;
  logic next_cfgErr;
  logic powerRst;
  assign powerRst = aonRst | lvRst | pinRst;
  always_comb begin
    next_state = state;
    next_failCnt = failCnt;
    next_cfgErr = 1'b0;
    case (state)
      RSC_CHECK: begin
        if (configCheckDone) begin
          if (configCheckFail) begin
            next_failCnt = failCnt + 1'b1;
            if (failCnt + 1'b1 == MAX_FAIL) begin
              next_state = RSC_PARK; // [R08]
            end else begin
              next_cfgErr = 1'b1; // [R07]
              next_state = RSC_RETRY;
            end
          end else begin
            // a pass clears the count, so only consecutive failures park
            next_failCnt = 2'h0;
            next_state = RSC_RUN;
          end
        end
      end
      RSC_RETRY: begin
        // hold the error until the restart has taken hold
        next_cfgErr = ~cfgRst;
        if (cfgRst) begin
          next_state = RSC_CHECK; // [R08]
        end
      end
      RSC_RUN: begin
        if (wdRst | swRst) begin
          next_state = RSC_CHECK;
        end
      end
      RSC_PARK: begin
        // recovery only by a power or pin reset
        next_state = RSC_PARK;
      end
      default: begin
        next_state = RSC_CHECK;
      end
    endcase
    if (powerRst) begin
      next_state = RSC_CHECK;
      next_failCnt = 2'h0;
      next_cfgErr = 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= RSC_CHECK;
      failCnt <= 2'h0;
      cfgErr <= 1'b0;
    end else begin
      state <= next_state;
      failCnt <= next_failCnt;
      cfgErr <= next_cfgErr;
    end
  end
  assign configCheckStart = (state == RSC_CHECK) & ~powerRst & ~cfgRst;
  assign emulatedDeepSleep = (state == RSC_PARK); // [R08]
  assign forceReadoutProtect = (state == RSC_PARK); // [R09]

  // ****************************************************
  // generated resets
  // ****************************************************
  logic lvFromWake;
  logic next_lvFromWake;
  logic lvRstDly;
  logic next_lvRstDly;
  logic parked;
  assign parked = (state == RSC_PARK);
  // a wake marks the coming low-voltage reset until that reset has ended
  always_comb begin
    next_lvRstDly = lvRst;
    next_lvFromWake = lvFromWake;
    if (deepSleepWake) begin
      next_lvFromWake = 1'b1;
    end else if (lvRstDly & ~lvRst) begin
      next_lvFromWake = 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lvFromWake <= 1'b0;
      lvRstDly <= 1'b0;
    end else begin
      lvFromWake <= next_lvFromWake;
      lvRstDly <= next_lvRstDly;
    end
  end
  logic lvHv;
  assign lvHv = lvRst & ~lvFromWake;
  // [R13]
  assign fullCpuDebugReset = aonRst | lvRst | pinRst | cfgRst;
  assign cpuOnlyReset = fullCpuDebugReset | wdRst | swRst | dbgRst | parked;
  assign debugAccessReset = aonRst | lvRst;
  assign retainedPeriphReset = aonRst | lvHv | pinRst | wdRst | swRst;
  assign corePeriphReset = fullCpuDebugReset | wdRst | swRst | parked;

  // ****************************************************
  // test port reset
  // ****************************************************
  // only the tap sees this; no other reset path reads it
  logic tapMeta;
  logic tapSync;
  logic next_tapMeta;
  logic next_tapSync;
  // inverted only after the second stage, so no logic sits ahead of it
  always_comb begin
    next_tapMeta = testPortResetPin_n;
    next_tapSync = tapMeta;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tapMeta <= 1'b1;
      tapSync <= 1'b1;
    end else begin
      tapMeta <= next_tapMeta;
      tapSync <= next_tapSync;
    end
  end
  assign tapReset = ~tapSync & ~twoWireMode & ~debugPortDisable; // [R11] [R12]

  // ****************************************************
  // cause record
  // ****************************************************
  rsc_cause_t cause;
  rsc_cause_t next_cause;
  // fixed priority: the most severe of overlapping sources is recorded
  always_comb begin
    next_cause = cause;
    if (aonRst) begin
      next_cause = RSC_CAUSE_AON; // [R14]
    end else if (lvRst & lvFromWake) begin
      next_cause = RSC_CAUSE_WAKE;
    end else if (lvRst) begin
      next_cause = RSC_CAUSE_LV;
    end else if (pinRst) begin
      next_cause = RSC_CAUSE_PIN;
    end else if (cfgRst) begin
      next_cause = RSC_CAUSE_CFG;
    end else if (wdRst) begin
      next_cause = RSC_CAUSE_WDOG;
    end else if (swRst) begin
      next_cause = RSC_CAUSE_SW;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cause <= RSC_CAUSE_NONE;
    end else begin
      cause <= next_cause;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resetCause <= '0;
    end else begin
      resetCause <= next_cause;
    end
  end
endmodule
`default_nettype wire

// >>> verif/rsc_flash_model.sv
// flash loader model answering configuration checks
`timescale 1ns/1ns
`default_nettype none
module rsc_flash_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic configCheckStart,
  input wire logic cpu_only_reset,
  input wire logic failNext,
  input wire logic slow,
  output logic configCheckDone,
  output logic configCheckFail
);
  logic [7:0] waitCnt;
  logic [7:0] lim;
  assign lim = slow ? 8'h28 : 8'h04;
  // one answer per start; a system reset restarts the loader
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt <= 8'h00;
      configCheckDone <= 1'b0;
      configCheckFail <= 1'b0;
    end else begin
      configCheckDone <= 1'b0;
      // result line is meaningless outside done, so keep it moving
      configCheckFail <= ~configCheckFail;
      if (!configCheckStart || cpu_only_reset) begin
        waitCnt <= 8'h00;
      end else if (waitCnt == lim) begin
        configCheckDone <= 1'b1;
        configCheckFail <= failNext;
        waitCnt <= waitCnt + 8'h01;
      end else if (waitCnt < lim) begin
        waitCnt <= waitCnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/rsc_monitor.sv
// concurrent checks on the reset source collector ports
`timescale 1ns/1ns
`default_nettype none
module rsc_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic alwaysOnSupplyMonitor,
  input wire logic coreSupplyMonitor,
  input wire logic memorySupplyMonitor,
  input wire logic externalResetPin_n,
  input wire logic watchdogExpire,
  input wire logic configCheckStart,
  input wire logic configCheckDone,
  input wire logic configCheckFail,
  input wire logic testPortResetPin_n,
  input wire logic twoWireMode,
  input wire logic debugPortDisable,
  input wire logic emulatedDeepSleep,
  input wire logic forceReadoutProtect,
  input wire logic fullCpuDebugReset,
  input wire logic cpuOnlyReset,
  input wire logic debugAccessReset,
  input wire logic retainedPeriphReset,
  input wire logic corePeriphReset,
  input wire logic tapReset
);
  logic [11:0] lowCnt;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // saturating count of low pin samples; a bound on the filter delay needs it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt <= 12'h000;
    end else begin
      lowCnt <= externalResetPin_n ? 12'h000 : lowCnt + {11'h000, lowCnt != 12'hfff};
    end
  end
  aon_all_a: assert property (alwaysOnSupplyMonitor |-> fullCpuDebugReset &&
    cpuOnlyReset && debugAccessReset && retainedPeriphReset && corePeriphReset)
    else $error("supply reset not on all outputs");
  lv_merge_a: assert property ((coreSupplyMonitor || memorySupplyMonitor) |->
    fullCpuDebugReset && debugAccessReset && corePeriphReset)
    else $error("low voltage reset missing");
  wdog_src_a: assert property (watchdogExpire |-> cpuOnlyReset &&
    retainedPeriphReset && corePeriphReset) else $error("watchdog reset missing");
  tap_gate_a: assert property (twoWireMode || debugPortDisable |-> !tapReset)
    else $error("tap reset while gated");
  tap_pin_a: assert property ((!testPortResetPin_n && !twoWireMode &&
    !debugPortDisable) [*3] |-> tapReset) else $error("tap reset late");
  pin_filt_a: assert property (lowCnt == 12'h4ba |-> fullCpuDebugReset)
    else $error("pin reset filter too slow");
  cfg_err_a: assert property (configCheckStart && configCheckDone && configCheckFail
    |=> cpuOnlyReset && corePeriphReset) else $error("config failure not reset");
  park_ro_a: assert property (emulatedDeepSleep |-> forceReadoutProtect &&
    cpuOnlyReset && corePeriphReset) else $error("parked state outputs wrong");
  cover property (emulatedDeepSleep);
  cover property (tapReset);
  cover property (lowCnt == 12'h4ba);
  cover property (debugAccessReset && !retainedPeriphReset);
endmodule
bind rsc_top rsc_monitor rsc_monitor_i (.*);
`default_nettype wire

// >>> verif/rsc_top_tb_top.sv
// self-checking bench of the reset source collector
`timescale 1ns/1ns
`default_nettype none
module rsc_top_tb_top;
  import rsc_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic alwaysOnSupplyMonitor = 1'b0, coreSupplyMonitor = 1'b0, memorySupplyMonitor = 1'b0;
  logic watchdogExpire = 1'b0, softwareResetRequest = 1'b0, debugPortResetRequest = 1'b0;
  logic deepSleepWake = 1'b0, externalResetPin_n = 1'b1, testPortResetPin_n = 1'b1;
  logic twoWireMode = 1'b0, debugPortDisable = 1'b0, failNext = 1'b0, slow = 1'b0;
  logic configCheckDone, configCheckFail, configCheckStart, emulatedDeepSleep;
  logic forceReadoutProtect, fullCpuDebugReset, cpuOnlyReset, debugAccessReset;
  logic retainedPeriphReset, corePeriphReset, tapReset;
  logic [CAUSE_W-1:0] resetCause;
  logic [4:0] outs;
  int fail_count = 0;
  int checks = 0;
  int cfgFails = 0;
  assign outs = {fullCpuDebugReset, cpuOnlyReset, debugAccessReset, retainedPeriphReset,
    corePeriphReset};
  rsc_top rsc_top_i (.*);
  rsc_flash_model rsc_flash_model_i (.*, .cpu_only_reset(fullCpuDebugReset));
  always #5 clock = ~clock;
  always @(posedge clock) if (configCheckDone === 1'b1 && configCheckFail === 1'b1) cfgFails++;
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // ends just after an edge so the design's updates have landed
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task set_src(input logic [6:0] s);
    @(posedge clock);
    {deepSleepWake, debugPortResetRequest, softwareResetRequest, watchdogExpire,
      memorySupplyMonitor, coreSupplyMonitor, alwaysOnSupplyMonitor} <= s;
  endtask
  task t_src(input logic [6:0] s, input logic [4:0] e, input logic [2:0] c);
    if (s[6]) begin
      set_src(7'h40);
      set_src(7'h00);
    end
    set_src(s & 7'h3f);
    tick(2);
    chk({3'h0, outs}, {3'h0, e});
    chk({5'h0, resetCause}, {5'h0, c});
    set_src(7'h00);
    tick(1);
    chk({3'h0, outs}, {3'h0, e});
    tick(5);
    chk({3'h0, outs}, 8'h00);
    $display("source test %h ended", s);
  endtask
  task t_pin;
    @(posedge clock) externalResetPin_n <= 1'b0;
    repeat (90) @(posedge clock);
    externalResetPin_n <= 1'b1;
    tick(1300);
    chk({3'h0, outs}, 8'h00);
    @(posedge clock) externalResetPin_n <= 1'b0;
    tick(1100);
    chk({3'h0, outs}, 8'h00);
    tick(200);
    chk({3'h0, outs}, 8'h1b);
    chk({5'h0, resetCause}, 8'h03);
    repeat (1300) @(posedge clock);
    externalResetPin_n <= 1'b1;
    tick(1300);
    chk({3'h0, outs}, 8'h00);
    $display("pin test ended");
  endtask
  task t_tap;
    @(posedge clock) testPortResetPin_n <= 1'b0;
    tick(3);
    chk({2'h0, tapReset, outs}, 8'h20);
    @(posedge clock) twoWireMode <= 1'b1;
    tick(1);
    chk({7'h0, tapReset}, 8'h00);
    @(posedge clock) twoWireMode <= 1'b0;
    debugPortDisable <= 1'b1;
    tick(1);
    chk({7'h0, tapReset}, 8'h00);
    @(posedge clock) debugPortDisable <= 1'b0;
    testPortResetPin_n <= 1'b1;
    tick(3);
    $display("test port test ended");
  endtask
  task t_cfg;
    @(posedge clock) failNext <= 1'b1;
    slow <= 1'b1;
    cfgFails = 0;
    set_src(7'h01);
    set_src(7'h00);
    for (int i = 0; i < 2000 && emulatedDeepSleep !== 1'b1; i++) tick(1);
    tick(20);
    chk({configCheckStart, emulatedDeepSleep, forceReadoutProtect, outs}, 8'h69);
    chk(8'(cfgFails), 8'h03);
    chk({5'h0, resetCause}, 8'h06);
    @(posedge clock) failNext <= 1'b0;
    slow <= 1'b0;
    set_src(7'h01);
    set_src(7'h00);
    tick(60);
    chk({1'b0, configCheckStart, emulatedDeepSleep, outs}, 8'h00);
    $display("config test ended");
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    tick(10);
    t_src(7'h01, 5'h1f, 3'h1);
    t_src(7'h02, 5'h1f, 3'h2);
    t_src(7'h04, 5'h1f, 3'h2);
    t_src(7'h42, 5'h1d, 3'h7);
    t_src(7'h08, 5'h0b, 3'h4);
    t_src(7'h10, 5'h0b, 3'h5);
    t_src(7'h20, 5'h08, 3'h5);
    t_src(7'h09, 5'h1f, 3'h1);
    t_pin();
    t_tap();
    t_cfg();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
